// ===== bench/gpio_board_pins.sv
`timescale 1ns/100ps
module gpio_board_pins
    import gpio_pkg::*;
(
    // design drive and board drive
    input pin_drive_type    drv,
    input wire logic [7:0]  ext,
    input wire logic [7:0]  ext_en,
    // level seen on the pins
    output logic     [7:0]  lvl
);
    // wired-and with board pull-ups, so released lines float high
    assign lvl = (drv.o | ~drv.oe) & (ext | ~ext_en);
endmodule

// ===== bench/gpio_ports_assertions.sv
`timescale 1ns/100ps
module gpio_ports_assertions
    import gpio_pkg::*;
(
    // apb
    input wire logic         pclk,
    input wire logic         presetn,
    input wire logic         psel,
    input wire logic         penable,
    input wire logic         pready,
    // ports
    input periph_enable_type periph_en,
    input periph_drive_type  periph_drive,
    input wire logic [7:0]   port_a_dir,
    input wire logic [7:0]   led_sink_on,
    input wire logic [7:0]   port_c_pin_i,
    input wire logic [7:0]   port_d_pin_i,
    input pin_drive_type     port_b_pin,
    input pin_drive_type     port_c_pin,
    input wire logic         second_ext_interrupt,
    input wire logic         irq_pullup_on,
    input wire logic [7:0]   key_interrupt_in
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_access; psel && penable && !pready |=> pready; endproperty
    a_access: assert property (p_access) else $error("no ready after access");
    property p_led; $past(presetn) |-> (led_sink_on & ~$past(port_a_dir)) == 8'h00; endproperty
    a_led: assert property (p_led) else $error("led sink on input pin");
    property p_odrain; port_b_pin.o[3:0] == 4'h0; endproperty
    a_odrain: assert property (p_odrain) else $error("open drain pin driven high");
    property p_second_ext_interrupt; $past(presetn) |-> second_ext_interrupt == $past(port_c_pin_i[0]); endproperty
    a_second_ext_interrupt: assert property (p_second_ext_interrupt) else $error("interrupt tap wrong");
    property p_pull; $past(presetn) |-> irq_pullup_on == !$past(periph_en.irq_pullup_disable); endproperty
    a_pull: assert property (p_pull) else $error("pullup wrong");
    property p_key;
        $past(presetn) |-> key_interrupt_in == $past(periph_en.key_interrupt_enable & port_d_pin_i);
    endproperty
    a_key: assert property (p_key) else $error("key input wrong");
    property p_spi;
        $past(presetn) && $past(periph_en.spi_port_on) |->
            port_c_pin.o[5:2] == $past(periph_drive.c_o[5:2]);
    endproperty
    a_spi: assert property (p_spi) else $error("spi drive wrong");
    property p_twowire;
        $past(presetn) && $past(periph_en.two_wire_module_on) |->
            port_b_pin.oe[1:0] == $past(periph_drive.b_oe[1:0] & ~periph_drive.b_o[1:0]);
    endproperty
    a_twowire: assert property (p_twowire) else $error("two wire drive wrong");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind gpio_ports gpio_ports_assertions u_gpio_ports_assertions (.pclk, .presetn, .psel, .penable, .pready,
    .periph_en, .periph_drive, .port_a_dir, .led_sink_on, .port_c_pin_i, .port_d_pin_i, .port_b_pin,
    .port_c_pin, .second_ext_interrupt, .irq_pullup_on, .key_interrupt_in);

// ===== bench/gpio_ports_bcd_led_drive_tb_top.sv
`timescale 1ns/100ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fail_count++; $display("FAIL t=%0t got %h exp %h", $time, a, b); end end
module gpio_ports_bcd_led_drive_tb_top
    import gpio_pkg::*;
();
    logic              pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0]       paddr = 12'h000;
    logic [31:0]       pwdata = 32'h0, prdata, prd;
    logic [3:0]        pstrb = 4'hF;
    logic              pready, pslverr, perr, second_ext_interrupt, irq_pullup_on;
    logic [7:0]        port_a_dir = 8'h00, ext = 8'h00, ext_en = 8'h00, led_sink_on, key_interrupt_in, b_i, c_i, d_i;
    pin_drive_type     b_pin, c_pin, d_pin;
    periph_enable_type periph_en = '0;
    periph_drive_type  periph_drive = '0;
    int                fail_count = 0, n_compared = 0;
    always #25 pclk = ~pclk;
    gpio_ports u_gpio_ports (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata,
        .pslverr, .periph_en, .periph_drive, .port_a_dir, .led_sink_on, .port_b_pin_i(b_i), .port_c_pin_i(c_i),
        .port_d_pin_i(d_i), .port_b_pin(b_pin), .port_c_pin(c_pin), .port_d_pin(d_pin), .second_ext_interrupt,
        .irq_pullup_on, .key_interrupt_in);
    gpio_board_pins u_board_b (.drv(b_pin), .ext, .ext_en, .lvl(b_i));
    gpio_board_pins u_board_c (.drv(c_pin), .ext, .ext_en, .lvl(c_i));
    gpio_board_pins u_board_d (.drv(d_pin), .ext, .ext_en, .lvl(d_i));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        // wait for the edge that samples pready high; only the watchdog ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        prd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] x);
        apb(1'b0, a, 8'h00);
        `CHK(prd, {24'h000000, x})
    endtask
    task automatic wt;
        repeat (2) @(negedge pclk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd(OFS_PORT_B_DIR, DIR_RESET);
        rd(OFS_PORT_C_DIR, DIR_RESET);
        rd(OFS_PORT_D_DIR, DIR_RESET);
        `CHK({b_pin.oe, c_pin.oe, d_pin.oe}, 24'h000000)
        rd(OFS_LED_SINK, LED_RESET);
    endtask
    task automatic t_out;
        apb(1'b1, OFS_PORT_D_DATA, 8'h5A);
        apb(1'b1, OFS_PORT_D_DIR, 8'hFF);
        apb(1'b1, OFS_PORT_C_DATA, 8'h00);
        apb(1'b1, OFS_PORT_C_DIR, 8'hFF);
        wt;
        `CHK(d_pin, 16'h5AFF)
        `CHK(c_pin, 16'h00FF)
        rd(OFS_PORT_D_DATA, 8'h5A);
    endtask
    task automatic t_in;
        @(posedge pclk);
        ext <= 8'h3C;
        ext_en <= 8'hF0;
        apb(1'b1, OFS_PORT_D_DIR, 8'h0F);
        rd(OFS_PORT_D_DATA, 8'h3A);
        apb(1'b1, OFS_PORT_D_DATA, 8'hC3);
        rd(OFS_PORT_D_DATA, 8'h33);
        apb(1'b1, OFS_PORT_D_DIR, 8'hFF);
        rd(OFS_PORT_D_DATA, 8'hC3);
    endtask
    task automatic t_periph;
        apb(1'b1, OFS_PORT_B_DATA, 8'h0A);
        apb(1'b1, OFS_PORT_B_DIR, 8'hFF);
        wt;
        `CHK(b_pin, 16'h00F5)
        @(posedge pclk);
        periph_drive <= {8'h55, 8'hFF, 8'hFC, 8'h7F};
        periph_en <= {1'b1, 1'b1, 4'b0101, 1'b1, 1'b1, 8'h00, 1'b0};
        wt;
        `CHK(b_pin, 16'h50FA)
        `CHK(c_pin, 16'hFC7F)
        rd(OFS_PORT_B_DATA, 8'h0A);
    endtask
    task automatic t_kbd;
        apb(1'b1, OFS_PORT_C_DIR, 8'hFE);
        apb(1'b1, OFS_PORT_D_DIR, 8'h00);
        @(posedge pclk);
        ext <= 8'h34;
        ext_en <= 8'hFF;
        periph_en <= {8'h00, 8'h0F, 1'b1};
        wt;
        `CHK(key_interrupt_in, 8'h04)
        `CHK({second_ext_interrupt, irq_pullup_on}, 2'b00)
    endtask
    task automatic t_led;
        apb(1'b1, OFS_LED_SINK, 8'hF0);
        @(posedge pclk);
        port_a_dir <= 8'h3C;
        wt;
        `CHK(led_sink_on, 8'h30)
        rd(12'h020, 8'h00);
        `CHK(perr, 1'b1)
        @(posedge pclk);
        pstrb <= 4'h0;
        apb(1'b1, OFS_LED_SINK, 8'h0F);
        pstrb <= 4'hF;
        rd(OFS_LED_SINK, 8'hF0);
    endtask
    task automatic t_hold;
        apb(1'b1, OFS_PORT_B_DATA, 8'h96);
        apb(1'b1, OFS_PORT_C_DATA, 8'h69);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFS_PORT_C_DIR, DIR_RESET);
        apb(1'b1, OFS_PORT_B_DIR, 8'hFF);
        apb(1'b1, OFS_PORT_C_DIR, 8'hFF);
        rd(OFS_PORT_B_DATA, 8'h96);
        rd(OFS_PORT_C_DATA, 8'h69);
    endtask
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_out;
        t_in;
        t_periph;
        t_kbd;
        t_led;
        t_hold;
        final_report;
    end
    initial begin
        repeat (3000) @(posedge pclk);
        fail_count++;
        final_report;
    end
endmodule

// ===== hw/gpio_port_pin.sv
`timescale 1ns/100ps
module gpio_port_pin
    import gpio_pkg::*;
#(
    parameter logic [7:0] OPEN_DRAIN = 8'h00
) (
    // register state
    input  wire logic [7:0] latch,
    input  wire logic [7:0] dir,
    // peripheral override
    input  wire logic [7:0] periph_own,
    input  wire logic [7:0] periph_o,
    input  wire logic [7:0] periph_oe,
    // pin side
    input  wire logic [7:0] pin_i,
    output pin_drive_type   drive,
    output logic      [7:0] read_value
);
    logic [7:0] o_raw;
    logic [7:0] oe_raw;

    always_comb begin
        o_raw  = (periph_own & periph_o) | (~periph_own & latch);
        oe_raw = (periph_own & periph_oe) | (~periph_own & dir);
        // open drain: drive only the low level, release otherwise
        drive.o  = o_raw & ~OPEN_DRAIN;
        drive.oe = oe_raw & ~(OPEN_DRAIN & o_raw);
        read_value = (dir & latch) | (~dir & pin_i);
    end
endmodule

// ===== hw/gpio_ports.sv
`timescale 1ns/100ps
module gpio_ports
    import gpio_pkg::*;
(
    // apb
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    input  wire logic [3:0]          pstrb,
    output logic                     pready,
    output logic      [31:0]         prdata,
    output logic                     pslverr,
    // peripheral control and drive
    input  periph_enable_type        periph_en,
    input  periph_drive_type         periph_drive,
    // port a direction, from the port a logic
    input  wire logic [7:0]          port_a_dir,
    output logic      [7:0]          led_sink_on,
    // pins
    input  wire logic [7:0]          port_b_pin_i,
    input  wire logic [7:0]          port_c_pin_i,
    input  wire logic [7:0]          port_d_pin_i,
    output pin_drive_type            port_b_pin,
    output pin_drive_type            port_c_pin,
    output pin_drive_type            port_d_pin,
    // peripheral inputs
    output logic                     second_ext_interrupt,
    output logic                     irq_pullup_on,
    output logic      [7:0]          key_interrupt_in
);
    // the port logic is written for eight-bit ports only
    if (PORT_WIDTH != 8) begin
        $error("port width must be 8");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // bus handshake state
    typedef enum logic [1:0] {
        BUS_IDLE   = 2'b01,
        BUS_ANSWER = 2'b10
    } bus_state_type;

    // positions in the one-hot register select
    localparam int SEL_B_DATA = 0;
    localparam int SEL_C_DATA = 1;
    localparam int SEL_D_DATA = 2;
    localparam int SEL_LED    = 3;
    localparam int SEL_B_DIR  = 4;
    localparam int SEL_C_DIR  = 5;
    localparam int SEL_D_DIR  = 6;

    ////////////////////////////////////////////////////////////////////////////////
    // port data latches
    logic [7:0]    port_b_latch;
    logic [7:0]    port_c_latch;
    logic [7:0]    port_d_latch;
    logic [7:0]    next_port_b_latch;
    logic [7:0]    next_port_c_latch;
    logic [7:0]    next_port_d_latch;

    // direction and led drive registers
    logic [7:0]    port_b_dir;
    logic [7:0]    port_c_dir;
    logic [7:0]    port_d_dir;
    logic [7:0]    led_sink_enable;
    logic [7:0]    next_port_b_dir;
    logic [7:0]    next_port_c_dir;
    logic [7:0]    next_port_d_dir;
    logic [7:0]    next_led_sink_enable;

    // bus side
    bus_state_type bus_state;
    bus_state_type next_bus_state;
    logic [6:0]    sel;
    logic          answer;
    logic          wr;
    logic [7:0]    read_byte;
    logic [31:0]   next_prdata;
    logic          next_pready;
    logic          next_pslverr;

    // per-port read values and peripheral ownership
    logic [7:0]    b_read;
    logic [7:0]    c_read;
    logic [7:0]    d_read;
    logic [7:0]    b_own;
    logic [7:0]    c_own;

    // next values of the registered outputs
    pin_drive_type next_b_pin;
    pin_drive_type next_c_pin;
    pin_drive_type next_d_pin;
    logic [7:0]    next_led_sink_on;
    logic          next_second_ext_interrupt;
    logic          next_irq_pullup_on;
    logic [7:0]    next_key_interrupt_in;

    ////////////////////////////////////////////////////////////////////////////////
    // byte-lane merge of a write; only lane 0 carries register bits
    function automatic logic [7:0] merge(input logic [7:0] old, input logic [31:0] d, input logic [3:0] s);
        merge = s[0] ? d[7:0] : old;
    endfunction

    // one-hot select of the register at an address, all zero when unmapped
    function automatic logic [6:0] reg_select(input logic [11:0] a);
        reg_select = 7'h00;
        unique case (a)
            OFS_PORT_B_DATA: reg_select = 7'h01;
            OFS_PORT_C_DATA: reg_select = 7'h02;
            OFS_PORT_D_DATA: reg_select = 7'h04;
            OFS_LED_SINK:    reg_select = 7'h08;
            OFS_PORT_B_DIR:  reg_select = 7'h10;
            OFS_PORT_C_DIR:  reg_select = 7'h20;
            OFS_PORT_D_DIR:  reg_select = 7'h40;
            default:         reg_select = 7'h00;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // pin ownership: an enabled peripheral takes its pins from the port logic
    always_comb begin
        b_own      = 8'h00;
        b_own[1:0] = {2{periph_en.two_wire_module_on}};
        b_own[3:2] = {2{periph_en.serial_module_on}};
        b_own[7:4] = periph_en.timer_chan_on;
        // port c bits 1:0 and all of port d stay with the port logic
        c_own      = 8'h00;
        c_own[5:2] = {4{periph_en.spi_port_on}};
        c_own[7:6] = {2{periph_en.infrared_serial_on}};
    end

    gpio_port_pin #(.OPEN_DRAIN(8'h0F)) u_port_b (
        .latch      (port_b_latch),
        .dir        (port_b_dir),
        .periph_own (b_own),
        .periph_o   (periph_drive.b_o),
        .periph_oe  (periph_drive.b_oe),
        .pin_i      (port_b_pin_i),
        .drive      (next_b_pin),
        .read_value (b_read)
    );

    gpio_port_pin #(.OPEN_DRAIN(8'h00)) u_port_c (
        .latch      (port_c_latch),
        .dir        (port_c_dir),
        .periph_own (c_own),
        .periph_o   (periph_drive.c_o),
        .periph_oe  (periph_drive.c_oe),
        .pin_i      (port_c_pin_i),
        .drive      (next_c_pin),
        .read_value (c_read)
    );

    gpio_port_pin #(.OPEN_DRAIN(8'h00)) u_port_d (
        .latch      (port_d_latch),
        .dir        (port_d_dir),
        .periph_own (8'h00),
        .periph_o   (8'h00),
        .periph_oe  (8'h00),
        .pin_i      (port_d_pin_i),
        .drive      (next_d_pin),
        .read_value (d_read)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // bus handshake: one wait state, pready answers the cycle after the first access cycle
    always_comb begin
        next_bus_state = BUS_IDLE;
        unique case (bus_state)
            BUS_IDLE: begin
                if (psel && penable) begin
                    next_bus_state = BUS_ANSWER;
                end
            end
            BUS_ANSWER: begin
                next_bus_state = BUS_IDLE;
            end
            default: begin
                next_bus_state = BUS_IDLE;
            end
        endcase
        answer       = (next_bus_state == BUS_ANSWER);
        next_pready  = answer;
        next_pslverr = answer && (sel == 7'h00);
        next_prdata  = 32'h00000000;
        if (answer && !pwrite) begin
            next_prdata = {24'h000000, read_byte};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_state <= BUS_IDLE;
            pready    <= 1'b0;
            pslverr   <= 1'b0;
            prdata    <= 32'h00000000;
        end else begin
            bus_state <= next_bus_state;
            pready    <= next_pready;
            pslverr   <= next_pslverr;
            prdata    <= next_prdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register read mux
    always_comb begin
        sel       = reg_select(paddr);
        read_byte = 8'h00;
        if (sel[SEL_B_DATA]) begin
            read_byte = b_read;
        end
        if (sel[SEL_C_DATA]) begin
            read_byte = c_read;
        end
        if (sel[SEL_D_DATA]) begin
            read_byte = d_read;
        end
        if (sel[SEL_LED]) begin
            read_byte = led_sink_enable;
        end
        if (sel[SEL_B_DIR]) begin
            read_byte = port_b_dir;
        end
        if (sel[SEL_C_DIR]) begin
            read_byte = port_c_dir;
        end
        if (sel[SEL_D_DIR]) begin
            read_byte = port_d_dir;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register writes take effect at the edge that completes the transfer
    always_comb begin
        wr                   = psel && penable && pwrite && (bus_state == BUS_ANSWER);
        next_port_b_latch    = port_b_latch;
        next_port_c_latch    = port_c_latch;
        next_port_d_latch    = port_d_latch;
        next_port_b_dir      = port_b_dir;
        next_port_c_dir      = port_c_dir;
        next_port_d_dir      = port_d_dir;
        next_led_sink_enable = led_sink_enable;
        if (wr && sel[SEL_B_DATA]) begin
            next_port_b_latch = merge(port_b_latch, pwdata, pstrb);
        end
        if (wr && sel[SEL_C_DATA]) begin
            next_port_c_latch = merge(port_c_latch, pwdata, pstrb);
        end
        if (wr && sel[SEL_D_DATA]) begin
            next_port_d_latch = merge(port_d_latch, pwdata, pstrb);
        end
        if (wr && sel[SEL_LED]) begin
            next_led_sink_enable = merge(led_sink_enable, pwdata, pstrb);
        end
        if (wr && sel[SEL_B_DIR]) begin
            next_port_b_dir = merge(port_b_dir, pwdata, pstrb);
        end
        if (wr && sel[SEL_C_DIR]) begin
            next_port_c_dir = merge(port_c_dir, pwdata, pstrb);
        end
        if (wr && sel[SEL_D_DIR]) begin
            next_port_d_dir = merge(port_d_dir, pwdata, pstrb);
        end
    end

    // latches have no reset term
    always_ff @(posedge pclk) begin
        port_b_latch <= next_port_b_latch;
        port_c_latch <= next_port_c_latch;
        port_d_latch <= next_port_d_latch;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_b_dir      <= DIR_RESET;
            port_c_dir      <= DIR_RESET;
            port_d_dir      <= DIR_RESET;
            led_sink_enable <= LED_RESET;
        end else begin
            port_b_dir      <= next_port_b_dir;
            port_c_dir      <= next_port_c_dir;
            port_d_dir      <= next_port_d_dir;
            led_sink_enable <= next_led_sink_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registered pin and peripheral outputs
    always_comb begin
        next_led_sink_on          = led_sink_enable & port_a_dir;
        next_second_ext_interrupt = port_c_pin_i[0];
        next_irq_pullup_on        = !periph_en.irq_pullup_disable;
        next_key_interrupt_in     = periph_en.key_interrupt_enable & port_d_pin_i;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_b_pin           <= '0;
            port_c_pin           <= '0;
            port_d_pin           <= '0;
            led_sink_on          <= 8'h00;
            second_ext_interrupt <= 1'b1;
            irq_pullup_on        <= 1'b1;
            key_interrupt_in     <= 8'h00;
        end else begin
            port_b_pin           <= next_b_pin;
            port_c_pin           <= next_c_pin;
            port_d_pin           <= next_d_pin;
            led_sink_on          <= next_led_sink_on;
            second_ext_interrupt <= next_second_ext_interrupt;
            irq_pullup_on        <= next_irq_pullup_on;
            key_interrupt_in     <= next_key_interrupt_in;
        end
    end
endmodule

// ===== inc/gpio_pkg.sv
// Overview of operation
// - led sink enable bit drives strong sink only while pin is an output
// - port b, c, d latches keep contents through reset
// - reset clears all port b, c, d direction bits to input
// - direction 1 drives the latch onto the pin, 0 leaves it floating
// - data read returns latch for outputs, pin level for inputs
// - data writes with byte lane 0 strobed update the latch regardless of direction
// - port b bits 3..0 are open drain, pull low only
// - two wire enable hands port b bits 0,1 to two wire module
// - serial enable hands port b bit 2 transmit, bit 3 receive
// - timer edge level select gives port b bits 4..7 to timers
// - port c bit 0 always feeds second interrupt, pullup unless disabled
// - spi enable hands port c bits 2..5 to spi
// - infrared serial enable hands port c bit 6 transmit, bit 7 receive
// - each key interrupt enable bit makes port d pin an interrupt input
package gpio_pkg;
    localparam int          PORT_WIDTH      = 8;
    // register index on the bus; the byte address is four times the index
    localparam logic [9:0]  IDX_PORT_B_DATA = 10'h001;
    localparam logic [9:0]  IDX_PORT_C_DATA = 10'h002;
    localparam logic [9:0]  IDX_PORT_D_DATA = 10'h003;
    localparam logic [9:0]  IDX_LED_SINK    = 10'h004;
    localparam logic [9:0]  IDX_PORT_B_DIR  = 10'h005;
    localparam logic [9:0]  IDX_PORT_C_DIR  = 10'h006;
    localparam logic [9:0]  IDX_PORT_D_DIR  = 10'h007;
    localparam logic [11:0] OFS_PORT_B_DATA = {IDX_PORT_B_DATA, 2'b00};
    localparam logic [11:0] OFS_PORT_C_DATA = {IDX_PORT_C_DATA, 2'b00};
    localparam logic [11:0] OFS_PORT_D_DATA = {IDX_PORT_D_DATA, 2'b00};
    localparam logic [11:0] OFS_LED_SINK    = {IDX_LED_SINK, 2'b00};
    localparam logic [11:0] OFS_PORT_B_DIR  = {IDX_PORT_B_DIR, 2'b00};
    localparam logic [11:0] OFS_PORT_C_DIR  = {IDX_PORT_C_DIR, 2'b00};
    localparam logic [11:0] OFS_PORT_D_DIR  = {IDX_PORT_D_DIR, 2'b00};
    localparam logic [7:0]  DIR_RESET       = 8'h00;
    localparam logic [7:0]  LED_RESET       = 8'h00;

    typedef struct packed {
        logic [7:0] o;
        logic [7:0] oe;
    } pin_drive_type;

    typedef struct packed {
        logic       two_wire_module_on;
        logic       serial_module_on;
        logic [3:0] timer_chan_on;
        logic       spi_port_on;
        logic       infrared_serial_on;
        logic [7:0] key_interrupt_enable;
        logic       irq_pullup_disable;
    } periph_enable_type;

    typedef struct packed {
        logic [7:0] b_o;
        logic [7:0] b_oe;
        logic [7:0] c_o;
        logic [7:0] c_oe;
    } periph_drive_type;
endpackage
